// file: pkg/qpno_pkg.sv
/*
 * Constants and types shared by the phase-correction and NCO phase-offset
 * register block. Assumes a single clock domain and AXI4-Lite register access.
 */
package qpno_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned REG_W = 16;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned SAMP_W = 16;
    localparam int unsigned PCORR_W = 12;
    localparam int unsigned PROD_W = 28;
    localparam int unsigned PCORR_FRAC = 12;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned ACC_HI_LSB = 16;
    localparam int unsigned SYNC_EN_BIT = 0;

    localparam logic [7:0] IDX_GAIN_OFFS_A = 8'h0E;
    localparam logic [7:0] IDX_GAIN_OFFS_B = 8'h0F;
    localparam logic [7:0] IDX_CD_PHASE_CORRECTION = 8'h11;
    localparam logic [7:0] IDX_AB_NCO_PHASE_OFFSET = 8'h12;
    localparam logic [7:0] IDX_FREQ_WORD_LOW = 8'h14;
    localparam logic [7:0] IDX_FREQ_WORD_HIGH = 8'h15;
    localparam logic [7:0] IDX_CORR_SYNC_EN = 8'h1E;
    localparam logic [7:0] IDX_MIX_SYNC_EN = 8'h1F;

    localparam logic [15:0] RST_GAIN_OFFS = 16'h0400;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [11:0] RST_ZERO12 = 12'h000;
    localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic
    {
        WR_COLLECT,
        WR_RESP
    } qpno_wr_state_type;
endpackage

// file: rtl/qpno_corr.sv
/*
 * Phase correction of one channel pair: the second sample times the
 * correction word is added into the first sample, with saturation.
 * Assumes samples and correction word are synchronous to the clock.
 */
`timescale 1ns/10ps
module qpno_corr
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic valid_i,
    input wire logic [qpno_pkg::SAMP_W-1:0] samp_c_i,
    input wire logic [qpno_pkg::SAMP_W-1:0] samp_d_i,
    input wire logic [qpno_pkg::PCORR_W-1:0] phase_i,
    output logic valid_o,
    output logic [qpno_pkg::SAMP_W-1:0] samp_c_o,
    output logic [qpno_pkg::SAMP_W-1:0] samp_d_o
);
    logic signed [qpno_pkg::PROD_W-1:0] prod;
    logic signed [qpno_pkg::SAMP_W:0] sum;

    always_comb
    begin
        prod = qpno_pkg::PROD_W'($signed(samp_d_i) * $signed(phase_i));
        sum = $signed({samp_c_i[qpno_pkg::SAMP_W-1], samp_c_i})
            + $signed(prod[qpno_pkg::PROD_W-1:qpno_pkg::PCORR_FRAC]);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            valid_o <= 1'b0;
            samp_c_o <= qpno_pkg::RST_ZERO16;
            samp_d_o <= qpno_pkg::RST_ZERO16;
        end
        else if (ce_i)
        begin
            valid_o <= valid_i;
            samp_d_o <= samp_d_i;
            if (sum[qpno_pkg::SAMP_W] != sum[qpno_pkg::SAMP_W-1])
                samp_c_o <= sum[qpno_pkg::SAMP_W] ? qpno_pkg::SAT_NEG
                                                  : qpno_pkg::SAT_POS;
            else
                samp_c_o <= sum[qpno_pkg::SAMP_W-1:0];
        end
    end
endmodule // qpno_corr

// file: rtl/qpno_nco.sv
/*
 * Phase accumulator of one fine mixer with phase offset; the output is the
 * sine and cosine table index. Assumes one accumulation per clock cycle.
 */
`timescale 1ns/10ps
module qpno_nco
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [qpno_pkg::ACC_W-1:0] freq_word_i,
    input wire logic [qpno_pkg::REG_W-1:0] phase_offset_i,
    output logic [qpno_pkg::REG_W-1:0] table_index_o
);
    logic [qpno_pkg::ACC_W-1:0] acc_q;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            acc_q <= qpno_pkg::RST_ZERO32;
        else if (ce_i)
            acc_q <= acc_q + freq_word_i;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            table_index_o <= qpno_pkg::RST_ZERO16;
        else if (ce_i)
            table_index_o <= acc_q[qpno_pkg::ACC_W-1:qpno_pkg::ACC_HI_LSB]
                + phase_offset_i;
    end
endmodule // qpno_nco

// file: rtl/qpno_regs.sv
/*
 * Register bank for the second pair's phase correction and the first pair's
 * NCO phase offset, with shadow registers, auto-sync and the datapath users.
 * Assumes an AXI4-Lite master on one clock and synchronous data inputs.
 */
`timescale 1ns/10ps
// Overview of operation
// - Pair2 correction: 12-bit signed, default zero.
// - Fourth sample times correction added to third.
// - Correction write with sync enabled loads group.
// - Gain/offset writes alone leave active unchanged.
// - Offset added to accumulator upper sixteen bits.
// - Sixteen-bit sum indexes sine/cosine tables.
// - Offset write with sync enabled loads mixer.
// - Frequency writes alone leave mixer unchanged.
// - Correction resets zero; bits 15:12 read zero.
// - Frequency word 32-bit signed, step Fs/2^32.
module qpno_regs
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [qpno_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [qpno_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [qpno_pkg::STRB_W-1:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [qpno_pkg::ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [qpno_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic ext_sync_i,
    input wire logic samp_valid_i,
    input wire logic [qpno_pkg::SAMP_W-1:0] samp_c_i,
    input wire logic [qpno_pkg::SAMP_W-1:0] samp_d_i,
    output logic corr_valid_o,
    output logic [qpno_pkg::SAMP_W-1:0] corr_c_o,
    output logic [qpno_pkg::SAMP_W-1:0] corr_d_o,
    output logic [qpno_pkg::REG_W-1:0] nco_table_index_o,
    output logic [qpno_pkg::REG_W-1:0] pair2_gain_offset_a_o,
    output logic [qpno_pkg::REG_W-1:0] pair2_gain_offset_b_o,
    output logic corr_sync_o,
    output logic mix_sync_o
);
    qpno_pkg::qpno_wr_state_type wr_state_q;
    logic [qpno_pkg::IDX_W-1:0] awidx_q;
    logic [qpno_pkg::REG_W-1:0] wdata_q;
    logic [1:0] wstrb_q;
    logic wr_fire;
    logic wr_mapped;

    logic [qpno_pkg::REG_W-1:0] gain_offs_a_q;
    logic [qpno_pkg::REG_W-1:0] gain_offs_b_q;
    logic [qpno_pkg::PCORR_W-1:0] pair2_phase_correction_q;
    logic [qpno_pkg::REG_W-1:0] pair1_nco_phase_offset_q;
    logic [qpno_pkg::REG_W-1:0] freq_word_low_q;
    logic [qpno_pkg::REG_W-1:0] freq_word_high_q;
    logic [qpno_pkg::REG_W-1:0] correction_sync_enable_reg_q;
    logic [qpno_pkg::REG_W-1:0] mixer_sync_enable_reg_q;

    logic [qpno_pkg::PCORR_W-1:0] act_phase_correction_q;
    logic [qpno_pkg::REG_W-1:0] act_phase_offset_q;
    logic [qpno_pkg::ACC_W-1:0] act_frequency_word_q;

    logic corr_load_d;
    logic mix_load_d;
    logic [qpno_pkg::DATA_W-1:0] rd_word;

    // Turns a byte address into a register index.
    function automatic logic [qpno_pkg::IDX_W-1:0] addr_to_idx
    (
        input logic [qpno_pkg::ADDR_W-1:0] addr
    );
        addr_to_idx = addr[qpno_pkg::IDX_LSB +: qpno_pkg::IDX_W];
    endfunction

    // Tells whether a register index is implemented.
    function automatic logic idx_mapped
    (
        input logic [qpno_pkg::IDX_W-1:0] idx
    );
        case (idx)
            qpno_pkg::IDX_GAIN_OFFS_A,
            qpno_pkg::IDX_GAIN_OFFS_B,
            qpno_pkg::IDX_CD_PHASE_CORRECTION,
            qpno_pkg::IDX_AB_NCO_PHASE_OFFSET,
            qpno_pkg::IDX_FREQ_WORD_LOW,
            qpno_pkg::IDX_FREQ_WORD_HIGH,
            qpno_pkg::IDX_CORR_SYNC_EN,
            qpno_pkg::IDX_MIX_SYNC_EN: idx_mapped = 1'b1;
            default: idx_mapped = 1'b0;
        endcase
    endfunction

    // Applies the two low byte strobes to a 16-bit register value.
    function automatic logic [qpno_pkg::REG_W-1:0] merge_bytes
    (
        input logic [qpno_pkg::REG_W-1:0] old_val,
        input logic [qpno_pkg::REG_W-1:0] new_val,
        input logic [1:0] strb
    );
        merge_bytes = {strb[1] ? new_val[15:8] : old_val[15:8],
                       strb[0] ? new_val[7:0] : old_val[7:0]};
    endfunction

    assign wr_fire = (wr_state_q == qpno_pkg::WR_COLLECT)
        && !s_axi_awready_o && !s_axi_wready_o;
    assign wr_mapped = idx_mapped(awidx_q);

    // Write address and data are taken in either order and held.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_awready_o <= 1'b1;
            awidx_q <= 8'h00;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                s_axi_awready_o <= 1'b0;
                awidx_q <= addr_to_idx(s_axi_awaddr_i);
            end
            else if (wr_state_q == qpno_pkg::WR_RESP && s_axi_bready_i)
                s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_wready_o <= 1'b1;
            wdata_q <= qpno_pkg::RST_ZERO16;
            wstrb_q <= 2'h0;
        end
        else if (ce_i)
        begin
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                s_axi_wready_o <= 1'b0;
                wdata_q <= s_axi_wdata_i[qpno_pkg::REG_W-1:0];
                wstrb_q <= s_axi_wstrb_i[1:0];
            end
            else if (wr_state_q == qpno_pkg::WR_RESP && s_axi_bready_i)
                s_axi_wready_o <= 1'b1;
        end
    end

    // Write response follows both halves of the write.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_state_q <= qpno_pkg::WR_COLLECT;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= qpno_pkg::RESP_OKAY;
        end
        else if (ce_i)
        begin
            case (wr_state_q)
                qpno_pkg::WR_COLLECT:
                begin
                    if (wr_fire)
                    begin
                        wr_state_q <= qpno_pkg::WR_RESP;
                        s_axi_bvalid_o <= 1'b1;
                        s_axi_bresp_o <= wr_mapped ? qpno_pkg::RESP_OKAY
                                                   : qpno_pkg::RESP_SLVERR;
                    end
                end
                qpno_pkg::WR_RESP:
                begin
                    if (s_axi_bready_i)
                    begin
                        wr_state_q <= qpno_pkg::WR_COLLECT;
                        s_axi_bvalid_o <= 1'b0;
                    end
                end
                default:
                begin
                    wr_state_q <= qpno_pkg::WR_COLLECT;
                    s_axi_bvalid_o <= 1'b0;
                end
            endcase
        end
    end

    // Shadow registers written by software.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gain_offs_a_q <= qpno_pkg::RST_GAIN_OFFS;
            gain_offs_b_q <= qpno_pkg::RST_GAIN_OFFS;
            pair2_phase_correction_q <= qpno_pkg::RST_ZERO12;
            pair1_nco_phase_offset_q <= qpno_pkg::RST_ZERO16;
            freq_word_low_q <= qpno_pkg::RST_ZERO16;
            freq_word_high_q <= qpno_pkg::RST_ZERO16;
            correction_sync_enable_reg_q <= qpno_pkg::RST_ZERO16;
            mixer_sync_enable_reg_q <= qpno_pkg::RST_ZERO16;
        end
        else if (ce_i && wr_fire)
        begin
            case (awidx_q)
                qpno_pkg::IDX_GAIN_OFFS_A:
                    gain_offs_a_q <= merge_bytes(gain_offs_a_q, wdata_q,
                                                 wstrb_q);
                qpno_pkg::IDX_GAIN_OFFS_B:
                    gain_offs_b_q <= merge_bytes(gain_offs_b_q, wdata_q,
                                                 wstrb_q);
                qpno_pkg::IDX_CD_PHASE_CORRECTION:
                    pair2_phase_correction_q <= qpno_pkg::PCORR_W'(
                        merge_bytes({4'h0, pair2_phase_correction_q},
                                    wdata_q, wstrb_q));
                qpno_pkg::IDX_AB_NCO_PHASE_OFFSET:
                    pair1_nco_phase_offset_q <= merge_bytes(
                        pair1_nco_phase_offset_q, wdata_q, wstrb_q);
                qpno_pkg::IDX_FREQ_WORD_LOW:
                    freq_word_low_q <= merge_bytes(freq_word_low_q, wdata_q,
                                                   wstrb_q);
                qpno_pkg::IDX_FREQ_WORD_HIGH:
                    freq_word_high_q <= merge_bytes(freq_word_high_q, wdata_q,
                                                    wstrb_q);
                qpno_pkg::IDX_CORR_SYNC_EN:
                    correction_sync_enable_reg_q <= merge_bytes(
                        correction_sync_enable_reg_q, wdata_q, wstrb_q);
                qpno_pkg::IDX_MIX_SYNC_EN:
                    mixer_sync_enable_reg_q <= merge_bytes(
                        mixer_sync_enable_reg_q, wdata_q, wstrb_q);
                default:
                begin
                end
            endcase
        end
    end

    // Sync requests: a write to the correction or the phase offset register while its sync enable bit 0 is set, or external.
    always_comb
    begin
        corr_load_d = ext_sync_i || (wr_fire
            && awidx_q == qpno_pkg::IDX_CD_PHASE_CORRECTION
            && correction_sync_enable_reg_q[qpno_pkg::SYNC_EN_BIT]);
        mix_load_d = ext_sync_i || (wr_fire
            && awidx_q == qpno_pkg::IDX_AB_NCO_PHASE_OFFSET
            && mixer_sync_enable_reg_q[qpno_pkg::SYNC_EN_BIT]);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            corr_sync_o <= 1'b0;
            mix_sync_o <= 1'b0;
        end
        else if (ce_i)
        begin
            corr_sync_o <= corr_load_d;
            mix_sync_o <= mix_load_d;
        end
    end

    // Correction group moves to the active side in one cycle.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pair2_gain_offset_a_o <= qpno_pkg::RST_GAIN_OFFS;
            pair2_gain_offset_b_o <= qpno_pkg::RST_GAIN_OFFS;
            act_phase_correction_q <= qpno_pkg::RST_ZERO12;
        end
        else if (ce_i && corr_sync_o)
        begin
            pair2_gain_offset_a_o <= gain_offs_a_q;
            pair2_gain_offset_b_o <= gain_offs_b_q;
            act_phase_correction_q <= pair2_phase_correction_q;
        end
    end

    // Mixer group moves to the active side in one cycle.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            act_phase_offset_q <= qpno_pkg::RST_ZERO16;
            act_frequency_word_q <= qpno_pkg::RST_ZERO32;
        end
        else if (ce_i && mix_sync_o)
        begin
            act_phase_offset_q <= pair1_nco_phase_offset_q;
            act_frequency_word_q <= {freq_word_high_q,
                                     freq_word_low_q};
        end
    end

    // Read data selection; reserved bits read as zero.
    always_comb
    begin
        rd_word = qpno_pkg::RST_ZERO32;
        case (addr_to_idx(s_axi_araddr_i))
            qpno_pkg::IDX_GAIN_OFFS_A:
                rd_word[qpno_pkg::REG_W-1:0] = gain_offs_a_q;
            qpno_pkg::IDX_GAIN_OFFS_B:
                rd_word[qpno_pkg::REG_W-1:0] = gain_offs_b_q;
            qpno_pkg::IDX_CD_PHASE_CORRECTION:
                rd_word[qpno_pkg::PCORR_W-1:0] = pair2_phase_correction_q;
            qpno_pkg::IDX_AB_NCO_PHASE_OFFSET:
                rd_word[qpno_pkg::REG_W-1:0] = pair1_nco_phase_offset_q;
            qpno_pkg::IDX_FREQ_WORD_LOW:
                rd_word[qpno_pkg::REG_W-1:0] = freq_word_low_q;
            qpno_pkg::IDX_FREQ_WORD_HIGH:
                rd_word[qpno_pkg::REG_W-1:0] = freq_word_high_q;
            qpno_pkg::IDX_CORR_SYNC_EN:
                rd_word[qpno_pkg::REG_W-1:0] = correction_sync_enable_reg_q;
            qpno_pkg::IDX_MIX_SYNC_EN:
                rd_word[qpno_pkg::REG_W-1:0] = mixer_sync_enable_reg_q;
            default:
                rd_word = qpno_pkg::RST_ZERO32;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= qpno_pkg::RST_ZERO32;
            s_axi_rresp_o <= qpno_pkg::RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= idx_mapped(addr_to_idx(s_axi_araddr_i))
                    ? qpno_pkg::RESP_OKAY : qpno_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    qpno_corr u_corr
    (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .valid_i(samp_valid_i),
        .samp_c_i(samp_c_i),
        .samp_d_i(samp_d_i),
        .phase_i(act_phase_correction_q),
        .valid_o(corr_valid_o),
        .samp_c_o(corr_c_o),
        .samp_d_o(corr_d_o)
    );

    qpno_nco u_nco
    (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .freq_word_i(act_frequency_word_q),
        .phase_offset_i(act_phase_offset_q),
        .table_index_o(nco_table_index_o)
    );
endmodule // qpno_regs

// file: bench/qpno_regs_assertions.sv
/* Checker for the register block, seeing only its top-level ports.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/10ps
module qpno_regs_chk
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic samp_valid_i,
    input wire logic [qpno_pkg::SAMP_W-1:0] samp_d_i,
    input wire logic corr_valid_o,
    input wire logic [qpno_pkg::SAMP_W-1:0] corr_d_o,
    input wire logic corr_sync_o,
    input wire logic mix_sync_o,
    input wire logic ext_sync_i,
    input wire logic [qpno_pkg::REG_W-1:0] pair2_gain_offset_a_o,
    input wire logic [qpno_pkg::REG_W-1:0] nco_table_index_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [qpno_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_rvalid_o,
    input wire logic [qpno_pkg::DATA_W-1:0] s_axi_rdata_o
);
    logic rd_corr_q;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_corr_q <= 1'b0;
        else if (ce_i && s_axi_arvalid_i && s_axi_arready_o)
            rd_corr_q <= (s_axi_araddr_i[qpno_pkg::IDX_LSB +:
                qpno_pkg::IDX_W] == qpno_pkg::IDX_CD_PHASE_CORRECTION);
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    valid_lag_a: assert property (ce_i |=>
        corr_valid_o == $past(samp_valid_i)) else $error("valid lag");
    d_lag_a: assert property (ce_i |=>
        corr_d_o == $past(samp_d_i)) else $error("d sample lag");
    corr_pulse_a: assert property (corr_sync_o && ce_i |=>
        !corr_sync_o) else $error("corr sync too long");
    mix_pulse_a: assert property (mix_sync_o && ce_i |=>
        !mix_sync_o) else $error("mix sync too long");
    corr_cause_a: assert property ($rose(corr_sync_o) |->
        s_axi_bvalid_o || $past(s_axi_bvalid_o) || $past(ext_sync_i) ||
        $past(ext_sync_i, 2)) else $error("sync without write");
    gain_hold_a: assert property ($changed(pair2_gain_offset_a_o) |->
        $past(corr_sync_o) || $past(ext_sync_i) || $past(ext_sync_i, 2))
        else $error("gain changed without sync");
    idx_freeze_a: assert property (!ce_i |=>
        $stable(nco_table_index_o)) else $error("index moved");
    rsvd_zero_a: assert property (s_axi_rvalid_o && rd_corr_q |->
        s_axi_rdata_o[15:12] == 4'h0) else $error("reserved bits set");
endmodule // qpno_regs_chk

bind qpno_regs qpno_regs_chk qpno_regs_chk_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .samp_valid_i(samp_valid_i),
    .samp_d_i(samp_d_i), .corr_valid_o(corr_valid_o), .corr_d_o(corr_d_o),
    .corr_sync_o(corr_sync_o), .mix_sync_o(mix_sync_o),
    .ext_sync_i(ext_sync_i), .pair2_gain_offset_a_o(pair2_gain_offset_a_o),
    .nco_table_index_o(nco_table_index_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rdata_o(s_axi_rdata_o));

// file: bench/tb_top.sv
/* Testbench: AXI4-Lite register accesses and datapath checks.
   Assumes the checker is attached by its own bind statement. */
`timescale 1ns/10ps
module tb_top;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, ext_sync_i = 1'b0, samp_valid_i = 1'b0;
    logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0;
    logic [31:0] s_axi_araddr_i = '0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [15:0] samp_c_i = '0, samp_d_i = '0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, corr_valid_o, corr_sync_o, mix_sync_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic [15:0] corr_c_o, corr_d_o, nco_table_index_o, ga_o, gb_o;
    int fail_count = 0, n_tests = 0, cyc = 0;

    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;

    qpno_regs qpno_regs_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_awaddr_i(s_axi_awaddr_i),
        .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
        .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_araddr_i(s_axi_araddr_i),
        .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
        .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
        .ext_sync_i(ext_sync_i), .samp_valid_i(samp_valid_i),
        .samp_c_i(samp_c_i), .samp_d_i(samp_d_i),
        .corr_valid_o(corr_valid_o), .corr_c_o(corr_c_o),
        .corr_d_o(corr_d_o), .nco_table_index_o(nco_table_index_o),
        .pair2_gain_offset_a_o(ga_o), .pair2_gain_offset_b_o(gb_o),
        .corr_sync_o(corr_sync_o), .mix_sync_o(mix_sync_o));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic finish_test;
        $display("mismatches %0d checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tmo(input bit done);
        if (!done)
        begin
            $display("BAD %0t wait expired", $time);
            fail_count++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
        input logic [1:0] er = 2'h0);
        bit b;
        b = 0;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (int n = 0; n < 50 && !b; n++)
        begin
            @(posedge core_clk_i);
            if (s_axi_awready_o)
                s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o)
                s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o)
            begin
                chk(s_axi_bresp_o, er);
                s_axi_bready_i <= 1'b0;
                b = 1;
            end
        end
        tmo(b);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ed,
        input logic [1:0] er = 2'h0);
        bit b;
        b = 0;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (int n = 0; n < 50 && !b; n++)
        begin
            @(posedge core_clk_i);
            if (s_axi_arready_o)
                s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o)
            begin
                chk(s_axi_rdata_o, ed);
                chk(s_axi_rresp_o, er);
                s_axi_rready_i <= 1'b0;
                b = 1;
            end
        end
        tmo(b);
    endtask

    task automatic snap(output logic [15:0] v, output int c);
        @(posedge core_clk_i);
        #1;
        v = nco_table_index_o;
        c = cyc;
    endtask

    initial
    begin
        logic [15:0] i0, i1;
        int c0, c1;
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd(32'h0000_0044, 32'h0000_0000);
        rd(32'h0000_0048, 32'h0000_0000);
        rd(32'h0000_0038, 32'h0000_0400);
        rd(32'h0000_0020, 32'h0000_0000, qpno_pkg::RESP_SLVERR);
        wr(32'h0000_0020, 32'h0000_1234, qpno_pkg::RESP_SLVERR);
        wr(32'h0000_0044, 32'h0000_F800);
        rd(32'h0000_0044, 32'h0000_0800);
        wr(32'h0000_0038, 32'h0000_0555);
        chk(ga_o, 32'h0000_0400);
        wr(32'h0000_0078, 32'h0000_0001);
        wr(32'h0000_0044, 32'h0000_0800);
        repeat (4) @(posedge core_clk_i);
        chk(ga_o, 32'h0000_0555);
        samp_c_i <= 16'h1000;
        samp_d_i <= 16'h2000;
        samp_valid_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(corr_c_o, 32'h0000_0000);
        chk(corr_d_o, 32'h0000_2000);
        chk(corr_valid_o, 32'h0000_0001);
        @(posedge core_clk_i);
        samp_c_i <= 16'h8000;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(corr_c_o, 32'h0000_8000);
        @(posedge core_clk_i);
        samp_c_i <= 16'h7FFF;
        samp_d_i <= 16'h8000;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(corr_c_o, 32'h0000_7FFF);
        chk(corr_d_o, 32'h0000_8000);
        wr(32'h0000_0078, 32'h0000_0000);
        wr(32'h0000_003C, 32'h0000_0222);
        chk(gb_o, 32'h0000_0400);
        @(posedge core_clk_i);
        ext_sync_i <= 1'b1;
        @(posedge core_clk_i);
        ext_sync_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        chk(gb_o, 32'h0000_0222);
        wr(32'h0000_007C, 32'h0000_0001);
        wr(32'h0000_0054, 32'h0000_0001);
        wr(32'h0000_0050, 32'h0000_0000);
        repeat (5) @(posedge core_clk_i);
        snap(i1, c1);
        chk(i1, 32'h0000_0000);
        wr(32'h0000_0048, 32'h0000_0000);
        repeat (4) @(posedge core_clk_i);
        snap(i0, c0);
        snap(i1, c1);
        chk(i1, 16'(i0 + 16'h0001));
        wr(32'h0000_0048, 32'h0000_0100);
        repeat (4) @(posedge core_clk_i);
        snap(i1, c1);
        chk(i1, 16'(i0 + 16'h0100 + 16'(c1 - c0)));
        wr(32'h0000_0054, 32'h0000_FFFF);
        wr(32'h0000_0048, 32'h0000_0100);
        repeat (4) @(posedge core_clk_i);
        snap(i0, c0);
        snap(i1, c1);
        chk(i1, 16'(i0 - 16'h0001));
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        snap(i0, c0);
        repeat (3) @(posedge core_clk_i);
        snap(i1, c1);
        chk(i1, i0);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        finish_test();
    end
endmodule // tb_top
